/* hw/snp_ms_tick.sv */
// Millisecond enable pulse divider
`timescale 1ns/100ps
module snp_ms_tick #(
	parameter int unsigned CYCLES = 40000
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	output logic      tick
);
	logic [15:0] cnt;

	// Count up one period, pulse one cycle at the wrap
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			cnt  <= 16'h0000;
			tick <= 1'b0;
		end
		else if (cnt == 16'(CYCLES - 1))
		begin
			cnt  <= 16'h0000;
			tick <= 1'b1;
		end
		else
		begin
			cnt  <= cnt + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule // snp_ms_tick

/* hw/snp_packer.sv */
// Serial byte packer with frame release rules, session control and Wishbone registers
`timescale 1ns/100ps
module snp_packer #(
	parameter int unsigned MS_CYCLES = snp_pkg::MS_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	output logic             wb_ack_o,
	output logic [31:0]      wb_dat_o,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	output logic             rx_ready,
	input  wire logic        dsr,
	input  wire logic        dcd,
	input  wire logic        remote_close,
	output logic             session_open,
	output logic             tx_valid,
	output logic [7:0]       tx_data,
	output logic             tx_last,
	output logic [10:0]      tx_len,
	output logic [15:0]      listen_port
);
	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] lane_merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
				r[i*8 +: 8] = dat[i*8 +: 8];
		end
		return r;
	endfunction

	logic [2:0]  conn_mode;
	logic [1:0]  dproc;
	logic [10:0] pkt_len;
	logic [7:0]  delim1;
	logic [7:0]  delim2;
	logic [15:0] force_ms;
	logic [15:0] inact_ms;
	logic [15:0] frames;
	logic [7:0]  mem [0:1023];
	logic [10:0] cnt;
	logic [10:0] drain_len;
	logic [9:0]  rd_idx;
	logic [1:0]  pend;
	logic        prev_d1;
	logic [15:0] gap_ms;
	logic [15:0] idle_ms;
	logic        started;
	logic        dsr_q;
	logic        dcd_q;
	logic        tick;
	snp_pkg::snp_state_e state;

	logic        wr_req;
	logic        take;
	logic        delim_on;
	logic        hit;
	logic        strip;
	logic        store;
	logic        pend_done;
	logic [10:0] next_cnt;
	logic        len_rel;
	logic        full_rel;
	logic        gap_rel;
	logic        release_now;
	logic [31:0] wr_word;

	snp_ms_tick #(
		.CYCLES (MS_CYCLES)
	) u_tick (
		.clk_sys (clk_sys),
		.rst     (rst),
		.tick    (tick)
	);

	// Bus write strobe: lands once, at the edge where the master samples ack high
	assign wr_req = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

	// Byte acceptance and delimiter match
	assign take     = rx_valid & rx_ready;
	assign delim_on = (delim1 != 8'h00);                              // RULE_05 RULE_07
	always_comb
	begin
		hit = 1'b0;
		if (take && delim_on && pend == 2'h0)
		begin
			if (delim2 == 8'h00)
				hit = (rx_data == delim1);                          // RULE_05
			else
				hit = prev_d1 && (rx_data == delim2);               // RULE_08
		end
	end
	assign strip     = hit && (dproc == snp_pkg::PROC_STRIP);       // RULE_11
	assign store     = take && !strip;
	assign pend_done = take && (pend == 2'h1);                      // RULE_10

	// Fill level after this byte; a stripped pair also drops the stored first char
	always_comb
	begin
		next_cnt = cnt + {10'h000, store};
		if (strip && delim2 != 8'h00)
			next_cnt = cnt - 11'h001;                                 // RULE_11
	end

	assign len_rel  = take && pkt_len != 11'h000 && next_cnt >= pkt_len; // RULE_01 RULE_02
	assign full_rel = take && next_cnt == snp_pkg::BUF_BYTES;           // RULE_06
	assign gap_rel  = !take && tick && force_ms != 16'h0000
		&& cnt != 11'h000 && gap_ms >= force_ms;                       // RULE_12

	// Every release condition folds into one decision per cycle
	assign release_now = (take && !delim_on)                         // RULE_03
		|| (hit && (dproc == snp_pkg::PROC_PLAIN || strip))           // RULE_04 RULE_09
		|| pend_done || len_rel || full_rel || gap_rel;               // RULE_21

	// Buffer write; the array holds no reset so it maps onto block RAM
	always_ff @(posedge clk_sys)
	begin
		if (store)
			mem[cnt[9:0]] <= rx_data;
	end

	// Fill counter, pending tail and first-delimiter memory
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			cnt     <= 11'h000;
			pend    <= 2'h0;
			prev_d1 <= 1'b0;
		end
		else if (release_now)
		begin
			cnt     <= 11'h000;                                         // RULE_20
			pend    <= 2'h0;
			prev_d1 <= 1'b0;
		end
		else if (take)
		begin
			cnt     <= next_cnt;
			prev_d1 <= (rx_data == delim1) && !strip;
			if (pend != 2'h0)
				pend <= pend - 2'h1;
			else if (hit && dproc == snp_pkg::PROC_PLUS1)
				pend <= 2'h1;                                           // RULE_10
			else if (hit && dproc == snp_pkg::PROC_PLUS2)
				pend <= 2'h2;                                           // RULE_10
		end
	end

	// Gap timer in whole ticks since the last byte, so a release is never early
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			gap_ms <= 16'h0000;
		else if (take || release_now)
			gap_ms <= 16'h0000;                                         // RULE_20
		else if (tick && cnt != 11'h000 && gap_ms != 16'hFFFF)
			gap_ms <= gap_ms + 16'h0001;
	end

	// Drain engine; new bytes are held off while a frame streams out
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state     <= snp_pkg::SNP_COLLECT;
			rx_ready  <= 1'b1;
			drain_len <= 11'h000;
			rd_idx    <= 10'h000;
			frames    <= 16'h0000;
		end
		else
		begin
			unique case (state)
				snp_pkg::SNP_COLLECT:
				begin
					if (release_now && next_cnt != 11'h000)
					begin
						state     <= snp_pkg::SNP_DRAIN;
						rx_ready  <= 1'b0;
						drain_len <= gap_rel ? cnt : next_cnt;
						rd_idx    <= 10'h000;
						frames    <= frames + 16'h0001;
					end
				end
				snp_pkg::SNP_DRAIN:
				begin
					rd_idx <= rd_idx + 10'h001;
					if ({1'b0, rd_idx} == drain_len - 11'h001)
					begin
						state    <= snp_pkg::SNP_COLLECT;
						rx_ready <= 1'b1;
					end
				end
			endcase
		end
	end

	// Frame stream to the network side, bytes in arrival order
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			tx_valid <= 1'b0;
			tx_data  <= 8'h00;
			tx_last  <= 1'b0;
			tx_len   <= 11'h000;
		end
		else if (state == snp_pkg::SNP_DRAIN)
		begin
			tx_valid <= 1'b1;
			tx_data  <= mem[rd_idx];                                    // RULE_20
			tx_last  <= ({1'b0, rd_idx} == drain_len - 11'h001);
			tx_len   <= drain_len;                                      // RULE_20
		end
		else
		begin
			tx_valid <= 1'b0;
			tx_last  <= 1'b0;
		end
	end

	// Edge memory for the modem-control inputs
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			dsr_q <= 1'b0;
			dcd_q <= 1'b0;
		end
		else
		begin
			dsr_q <= dsr;
			dcd_q <= dcd;
		end
	end

	// Inactivity timer, runs in every mode while the session is open
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			idle_ms <= 16'h0000;
		else if (take || !session_open)
			idle_ms <= 16'h0000;
		else if (tick && idle_ms != 16'hFFFF)
			idle_ms <= idle_ms + 16'h0001;
	end

	// Session open/close; remote close always wins over local opening
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			session_open <= 1'b0;
			started      <= 1'b0;
		end
		else if (remote_close)
			session_open <= 1'b0;                                       // RULE_19
		else
		begin
			unique case (conn_mode)
				snp_pkg::CONN_STARTUP:
				begin
					started <= 1'b1;
					if (!started)
						session_open <= 1'b1;                           // RULE_14
				end
				snp_pkg::CONN_CHAR:
				begin
					if (take)
						session_open <= 1'b1;                           // RULE_15
				end
				snp_pkg::CONN_CHAR_INA:
				begin
					if (take)
						session_open <= 1'b1;                           // RULE_15
					else if (inact_ms != 16'h0000 && tick
						&& idle_ms >= inact_ms)
						session_open <= 1'b0;                           // RULE_15 RULE_19
				end
				snp_pkg::CONN_DSR_OFF, snp_pkg::CONN_DSR:
				begin
					if (dsr && !dsr_q)
						session_open <= 1'b1;                           // RULE_16
					else if (!dsr && dsr_q && conn_mode == snp_pkg::CONN_DSR_OFF)
						session_open <= 1'b0;                           // RULE_16
				end
				snp_pkg::CONN_DCD_OFF, snp_pkg::CONN_DCD:
				begin
					if (dcd && !dcd_q)
						session_open <= 1'b1;                           // RULE_17
					else if (!dcd && dcd_q && conn_mode == snp_pkg::CONN_DCD_OFF)
						session_open <= 1'b0;                           // RULE_17
				end
				default:
					session_open <= session_open;
			endcase
		end
	end

	// Merged write word for the addressed register
	always_comb
	begin
		unique case (wb_adr_i)
			snp_pkg::ADR_CTRL:  wr_word = lane_merge({26'h0, dproc, 1'b0, conn_mode},
				wb_dat_i, wb_sel_i);
			snp_pkg::ADR_PLEN:  wr_word = lane_merge({21'h0, pkt_len}, wb_dat_i, wb_sel_i);
			snp_pkg::ADR_DELIM: wr_word = lane_merge({16'h0, delim2, delim1}, wb_dat_i,
				wb_sel_i);
			snp_pkg::ADR_FORCE: wr_word = lane_merge({16'h0, force_ms}, wb_dat_i, wb_sel_i);
			snp_pkg::ADR_INACT: wr_word = lane_merge({16'h0, inact_ms}, wb_dat_i, wb_sel_i);
			snp_pkg::ADR_LPORT: wr_word = lane_merge({16'h0, listen_port}, wb_dat_i,
				wb_sel_i);
			default:            wr_word = 32'h0000_0000;
		endcase
	end

	// Configuration registers; unmapped writes are dropped
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			conn_mode   <= snp_pkg::CONN_STARTUP;
			dproc       <= snp_pkg::PROC_PLAIN;
			pkt_len     <= snp_pkg::PLEN_RST;
			delim1      <= snp_pkg::DELIM_RST;
			delim2      <= snp_pkg::DELIM_RST;
			force_ms    <= snp_pkg::FORCE_RST;
			inact_ms    <= snp_pkg::INACT_RST;
			listen_port <= snp_pkg::LPORT_RST;                          // RULE_18
		end
		else if (wr_req)
		begin
			unique case (wb_adr_i)
				snp_pkg::ADR_CTRL:
				begin
					conn_mode <= wr_word[snp_pkg::CTRL_MODE_LSB +: 3];
					dproc     <= wr_word[snp_pkg::CTRL_PROC_LSB +: 2];
				end
				snp_pkg::ADR_PLEN:
				begin
					// Low 11-bit values beyond the buffer are clamped to it; upper bits are ignored
					if (wr_word[10:0] > snp_pkg::BUF_BYTES)
						pkt_len <= snp_pkg::BUF_BYTES;
					else
						pkt_len <= wr_word[10:0];
				end
				snp_pkg::ADR_DELIM:
				begin
					delim1 <= wr_word[7:0];
					delim2 <= wr_word[snp_pkg::DELIM2_LSB +: 8];
				end
				snp_pkg::ADR_FORCE: force_ms <= wr_word[15:0];
				snp_pkg::ADR_INACT: inact_ms <= wr_word[15:0];
				snp_pkg::ADR_LPORT:
				begin
					if (wr_word[15:0] != 16'h0000)
						listen_port <= wr_word[15:0];                   // RULE_18
				end
				default:
					listen_port <= listen_port;
			endcase
		end
	end

	// Bus answer one cycle after the request; unmapped reads return zero
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			unique case (wb_adr_i)
				snp_pkg::ADR_CTRL:   wb_dat_o <= {26'h0, dproc, 1'b0, conn_mode};
				snp_pkg::ADR_PLEN:   wb_dat_o <= {21'h0, pkt_len};
				snp_pkg::ADR_DELIM:  wb_dat_o <= {16'h0, delim2, delim1};
				snp_pkg::ADR_FORCE:  wb_dat_o <= {16'h0, force_ms};
				snp_pkg::ADR_INACT:  wb_dat_o <= {16'h0, inact_ms};
				snp_pkg::ADR_LPORT:  wb_dat_o <= {16'h0, listen_port};
				snp_pkg::ADR_STATUS: wb_dat_o <= {14'h0, state == snp_pkg::SNP_DRAIN,
					session_open, 5'h00, cnt};
				snp_pkg::ADR_FRAMES: wb_dat_o <= {16'h0, frames};
				default:             wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end
endmodule // snp_packer

/* include/snp_pkg.sv */
// Constants for the serial-to-network packer: register map, fields, resets, timing
// Function
// RULE_01 - Length zero: no length limit applies
// RULE_02 - Release frame when count reaches length
// RULE_03 - No delimiter: forward every byte at once
// RULE_04 - Delimiter set: hold bytes until it arrives
// RULE_05 - Second zero: single; both zero: off
// RULE_06 - Full buffer releases frame without delimiter
// RULE_07 - Delimiter works only with first enabled
// RULE_08 - Two characters must arrive back to back
// RULE_09 - Plain option sends data with delimiter
// RULE_10 - Plus options wait one or two bytes
// RULE_11 - Strip option drops delimiter, sends rest
// RULE_12 - Gap timeout releases frame; zero disables
// RULE_13 - Serial side keeps gaps short, size bounded
// RULE_14 - Startup option opens session, never closes
// RULE_15 - First character opens; optional inactivity close
// RULE_16 - Ready input opens; option closes on off
// RULE_17 - Carrier input opens; option closes on off
// RULE_18 - Listen port 1 to 65535, default 4001
// RULE_19 - Inactivity zero: open until remote close
// RULE_20 - Release hands bytes in order, restarts counters
// RULE_21 - Concurrent conditions give exactly one frame
package snp_pkg;
	// Register byte offsets
	localparam logic [7:0]  ADR_CTRL   = 8'h00;
	localparam logic [7:0]  ADR_PLEN   = 8'h04;
	localparam logic [7:0]  ADR_DELIM  = 8'h08;
	localparam logic [7:0]  ADR_FORCE  = 8'h0C;
	localparam logic [7:0]  ADR_INACT  = 8'h10;
	localparam logic [7:0]  ADR_LPORT  = 8'h14;
	localparam logic [7:0]  ADR_STATUS = 8'h18;
	localparam logic [7:0]  ADR_FRAMES = 8'h1C;
	// Field positions
	localparam int          CTRL_MODE_LSB = 0;
	localparam int          CTRL_PROC_LSB = 4;
	localparam int          DELIM2_LSB    = 8;
	localparam int          STAT_OPEN_BIT = 16;
	localparam int          STAT_DRN_BIT  = 17;
	// Connection-control encodings
	localparam logic [2:0]  CONN_STARTUP  = 3'h0;
	localparam logic [2:0]  CONN_CHAR     = 3'h1;
	localparam logic [2:0]  CONN_CHAR_INA = 3'h2;
	localparam logic [2:0]  CONN_DSR_OFF  = 3'h3;
	localparam logic [2:0]  CONN_DSR      = 3'h4;
	localparam logic [2:0]  CONN_DCD_OFF  = 3'h5;
	localparam logic [2:0]  CONN_DCD      = 3'h6;
	// Delimiter handling encodings
	localparam logic [1:0]  PROC_PLAIN    = 2'h0;
	localparam logic [1:0]  PROC_PLUS1    = 2'h1;
	localparam logic [1:0]  PROC_PLUS2    = 2'h2;
	localparam logic [1:0]  PROC_STRIP    = 2'h3;
	// Reset values
	localparam logic [10:0] PLEN_RST      = 11'h000;
	localparam logic [7:0]  DELIM_RST     = 8'h00;
	localparam logic [15:0] FORCE_RST     = 16'h0000;
	localparam logic [15:0] INACT_RST     = 16'h0000;
	localparam logic [15:0] LPORT_RST     = 16'hFA1;
	// Buffer and timing
	localparam logic [10:0] BUF_BYTES     = 11'h400;
	localparam int          CLK_NS        = 25;
	localparam int          MS_NS         = 1000000;
	localparam int unsigned MS_CYCLES     = MS_NS / CLK_NS;
	// Collect and drain states of the drain engine
	typedef enum logic {SNP_COLLECT, SNP_DRAIN} snp_state_e;
endpackage

/* test/snp_chk.sv */
// Port checker for the serial-to-network packer
`timescale 1ns/100ps
module snp_chk (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        rx_valid,
	input wire logic        rx_ready,
	input wire logic        dsr,
	input wire logic        dcd,
	input wire logic        remote_close,
	input wire logic        session_open,
	input wire logic        tx_valid,
	input wire logic        tx_last,
	input wire logic [10:0] tx_len
);
	logic [10:0] bcnt;
	// Byte index in the frame on the wire, so the length can be cross-checked
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
			bcnt <= 11'h000;
		else if (tx_valid)
			bcnt <= tx_last ? 11'h000 : bcnt + 11'h001;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_take;
		rx_valid && rx_ready ##1 !rx_ready;
	endsequence
	sequence s_tail;
		tx_valid && tx_last && rx_ready ##1 !tx_valid;
	endsequence
	ack_pulse_a: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack is not one pulse one cycle after request");
	release_start_a: assert property (s_take |=> tx_valid)
		else $error("frame did not start after releasing byte");
	drain_hold_a: assert property (tx_valid && !tx_last |-> !rx_ready)
		else $error("serial input open while frame drains");
	frame_run_a: assert property (tx_valid && !tx_last |=> tx_valid && $stable(tx_len))
		else $error("frame bytes not contiguous or length moved");
	frame_tail_a: assert property (tx_valid && tx_last |-> s_tail)
		else $error("frame end did not reopen serial input");
	frame_len_a: assert property (tx_valid && tx_last |-> tx_len == bcnt + 11'h001)
		else $error("frame length differs from bytes sent");
	len_bound_a: assert property (tx_valid |-> tx_len inside {[11'h001:11'h400]})
		else $error("frame length out of range");
	remote_close_a: assert property (remote_close && !rx_valid && $stable(dsr) && $stable(dcd)
		|=> !session_open)
		else $error("session stayed open after remote close");
endmodule // snp_chk
bind snp_packer snp_chk chk_u (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rx_valid,
	.rx_ready, .dsr, .dcd, .remote_close, .session_open, .tx_valid, .tx_last, .tx_len);

/* test/snp_serial_src.sv */
// Serial device model that offers queued bytes to the packer
`timescale 1ns/100ps
module snp_serial_src (
	input wire logic   clk_sys,
	input wire logic   rst,
	input wire logic   rx_ready,
	output logic       rx_valid,
	output logic [7:0] rx_data
);
	logic [7:0] q[$];
	initial
	begin
		rx_valid = 1'b0;
		rx_data  = 8'h00;
	end
	// Hold each byte until taken; idle data toggles so a stale byte never looks valid
	always @(posedge clk_sys)
		if (rx_valid && rx_ready)
		begin
			rx_valid <= 1'b0;
			rx_data  <= ~rx_data;
		end
		else if (!rx_valid && !rst && q.size() > 0)
		begin
			rx_valid <= 1'b1;
			rx_data  <= q.pop_front();
		end
		else if (!rx_valid)
			rx_data <= ~rx_data;
endmodule // snp_serial_src

/* test/testbench.sv */
// Self-checking bench for the serial-to-network packer
`timescale 1ns/100ps
module testbench;
	logic        clk_sys, rst, cyc, stb, we, dsr, dcd, rclose;
	logic [7:0]  adr, rx_data, tx_data;
	logic [31:0] wdat, rdat, dat_o;
	logic        ack, rx_valid, rx_ready, sopen, tx_valid, tx_last;
	logic [10:0] tx_len;
	logic [15:0] lport;
	int          err_count = 0;
	int          cmp_count = 0;
	logic [7:0]  fb[$], eb[$];
	logic [10:0] fl[$], el[$];
	snp_packer #(.MS_CYCLES(10)) dut_u (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(4'hF), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_ack_o(ack), .wb_dat_o(dat_o), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_ready(rx_ready), .dsr(dsr), .dcd(dcd), .remote_close(rclose),
		.session_open(sopen), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_len(tx_len), .listen_port(lport));
	snp_serial_src src_u (.clk_sys(clk_sys), .rst(rst), .rx_ready(rx_ready),
		.rx_valid(rx_valid), .rx_data(rx_data));
	// Clock at 40 MHz
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// Network side takes one byte a cycle, no stall possible
	always @(posedge clk_sys)
		if (tx_valid === 1'b1)
		begin
			fb.push_back(tx_data);
			if (tx_last)
				fl.push_back(tx_len);
		end
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Classic single cycle; request held until ack is sampled
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk_sys);
		while (ack !== 1'b1) @(posedge clk_sys);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h0);
		chk(nm, e, rdat);
	endtask
	task send(input logic [7:0] b, input bit keep);
		src_u.q.push_back(b);
		if (keep)
			eb.push_back(b);
	endtask
	// Wait for the model to empty, then leave room for a gap release
	task flush;
		for (int i = 0; i < 5000 && (src_u.q.size() > 0 || rx_valid); i++) @(posedge clk_sys);
		if (src_u.q.size() > 0 || rx_valid)
		begin
			err_count++;
			$display("CHECK FAILED flush expected empty seen busy");
		end
		tick(40);
	endtask
	task clr;
		fl.delete();
		fb.delete();
		el.delete();
		eb.delete();
	endtask
	task cmp_out(input string nm);
		flush();
		chk({nm, " frames"}, el.size(), fl.size());
		for (int i = 0; i < el.size() && i < fl.size(); i++) chk({nm, " len"}, el[i], fl[i]);
		chk({nm, " bytes"}, eb.size(), fb.size());
		for (int i = 0; i < eb.size() && i < fb.size(); i++) chk({nm, " data"}, eb[i], fb[i]);
		clr();
		$display("test %s done", nm);
	endtask
	task t_regs;
		chk("session at start", 32'h1, {31'h0, sopen});
		rd(snp_pkg::ADR_LPORT, 32'h0FA1, "port reg");
		chk("port pins", 32'h0FA1, {16'h0, lport});
		wb(1'b1, snp_pkg::ADR_LPORT, 32'h0);
		rd(snp_pkg::ADR_LPORT, 32'h0FA1, "port zero");
		wb(1'b1, snp_pkg::ADR_LPORT, 32'hFFFF);
		rd(snp_pkg::ADR_LPORT, 32'hFFFF, "port max");
		rd(snp_pkg::ADR_PLEN, 32'h0, "plen reset");
		rd(snp_pkg::ADR_DELIM, 32'h0, "delim reset");
		rd(snp_pkg::ADR_FORCE, 32'h0, "force reset");
		rd(8'h20, 32'h0, "unmapped");
		wb(1'b1, snp_pkg::ADR_PLEN, 32'h7D0);
		rd(snp_pkg::ADR_PLEN, 32'h400, "plen clamp");
		wb(1'b1, snp_pkg::ADR_PLEN, 32'h0);
		$display("test regs done");
	endtask
	task t_frames;
		send(8'h41, 1);
		send(8'h0D, 1);
		el = '{11'h1, 11'h1};
		cmp_out("no delim");
		wb(1'b1, snp_pkg::ADR_DELIM, 32'h0A00);
		send(8'h41, 1);
		send(8'h0A, 1);
		el = '{11'h1, 11'h1};
		cmp_out("delim2 only");
		wb(1'b1, snp_pkg::ADR_FORCE, 32'h1);
		wb(1'b1, snp_pkg::ADR_DELIM, 32'h0D);
		for (int p = 0; p < 4; p++)
		begin
			wb(1'b1, snp_pkg::ADR_CTRL, p << snp_pkg::CTRL_PROC_LSB);
			send(8'h41, 1);
			send(8'h42, 1);
			send(8'h0D, p != 3);
			send(8'h43, 1);
			send(8'h44, 1);
			case (p)
				0: el = '{11'h3, 11'h2};
				1: el = '{11'h4, 11'h1};
				2: el = '{11'h5};
				default: el = '{11'h2, 11'h2};
			endcase
			cmp_out("option");
		end
		wb(1'b1, snp_pkg::ADR_CTRL, 32'h0);
		wb(1'b1, snp_pkg::ADR_DELIM, 32'h0A0D);
		foreach (eb[i]) send(8'h0, 0);
		src_u.q = '{8'h41, 8'h0D, 8'h42, 8'h0D, 8'h0A, 8'h43};
		eb = src_u.q;
		el = '{11'h5, 11'h1};
		cmp_out("pair");
		wb(1'b1, snp_pkg::ADR_PLEN, 32'h3);
		for (int i = 0; i < 7; i++) send(8'h30 + i[7:0], 1);
		el = '{11'h3, 11'h3, 11'h1};
		cmp_out("length");
		wb(1'b1, snp_pkg::ADR_PLEN, 32'h0);
		wb(1'b1, snp_pkg::ADR_FORCE, 32'h0);
		for (int i = 0; i < 1030; i++) send(8'h20 + i[5:0], i < 1024);
		el = '{11'h400};
		cmp_out("full");
		rd(snp_pkg::ADR_STATUS, 32'h0001_0006, "status fill");
		for (int i = 1024; i < 1030; i++) eb.push_back(8'h20 + i[5:0]);
		wb(1'b1, snp_pkg::ADR_FORCE, 32'h1);
		el = '{11'h6};
		cmp_out("gap");
		rd(snp_pkg::ADR_FRAMES, 32'h12, "frame count");
	endtask
	task rclose_pulse;
		@(posedge clk_sys);
		rclose <= 1'b1;
		@(posedge clk_sys);
		rclose <= 1'b0;
		tick(3);
	endtask
	task t_session;
		// Pass 0 and 1 use the inactivity mode, pass 2 the keep-open mode
		for (int t = 0; t < 3; t++)
		begin
			wb(1'b1, snp_pkg::ADR_CTRL,
				{29'h0, t == 2 ? snp_pkg::CONN_CHAR : snp_pkg::CONN_CHAR_INA});
			wb(1'b1, snp_pkg::ADR_INACT, {31'h0, t != 0});
			rclose_pulse();
			chk("closed", 32'h0, {31'h0, sopen});
			send(8'h41, 0);
			tick(8);
			chk("char open", 32'h1, {31'h0, sopen});
			tick(60);
			chk("inactivity", {31'h0, t != 1}, {31'h0, sopen});
		end
		for (int m = 3; m < 7; m++)
		begin
			wb(1'b1, snp_pkg::ADR_CTRL, m);
			rclose_pulse();
			chk("line closed", 32'h0, {31'h0, sopen});
			for (int v = 1; v >= 0; v--)
			begin
				@(posedge clk_sys);
				if (m < 5)
					dsr <= v[0];
				else
					dcd <= v[0];
				tick(3);
				chk("line", {31'h0, v == 1 || m == 4 || m == 6}, {31'h0, sopen});
			end
		end
		clr();
		$display("test session done");
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Main sequence: reset for 12 cycles, then each scenario in turn
	initial
	begin
		{rst, cyc, stb, we, dsr, dcd, rclose} = 7'h40;
		adr = 8'h00;
		wdat = 32'h0;
		tick(12);
		rst <= 1'b0;
		tick(2);
		t_regs();
		t_frames();
		t_session();
		finish_test();
	end
	// Cut a hang well past the expected run of about 4000 cycles
	initial
	begin
		tick(30000);
		err_count++;
		$display("CHECK FAILED watchdog expected done seen timeout");
		finish_test();
	end
endmodule // testbench
